//--- core/proc_chan_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 48 kHz sample beats, 250 MHz system clock
// Notes: Register address is {channel[2:0], register[3:0]}
`ifndef PROC_CHAN_MAP_SVH
`define PROC_CHAN_MAP_SVH

// ****************************************
// Sizes
// ****************************************
`define NUM_CHAN 8
`define NUM_SECT 4
`define NUM_COEF 5
`define DW 24
`define CW 18
`define COEF_FRAC 16
`define GAIN_FRAC 14
`define FS_HZ 48000

// ****************************************
// Register offsets
// ****************************************
`define REG_CTRL 4'h0
`define REG_THRESH 4'h1
`define REG_RATIO 4'h2
`define REG_ATTACK 4'h3
`define REG_RELEASE 4'h4
`define REG_GAIN_ABS 4'h5
`define REG_GAIN_REL 4'h6
`define REG_GAIN_LIM 4'h7
`define REG_DELAY 4'h8
`define REG_IN_METER 4'h9
`define REG_GR_METER 4'hA
`define REG_FILT_CTRL 4'hB
`define REG_FILT_COEF 4'hC

// ****************************************
// Field positions
// ****************************************
`define CTRL_MUTE 0
`define CTRL_CMP_EN 1
`define CTRL_FILT_BYP 2
`define CTRL_DLY_BYP 3
`define CTRL_GRP_LSB 4
`define CTRL_GRP_MSB 6
`define FCTL_SECT_LSB 0
`define FCTL_SECT_MSB 1
`define FCTL_EN 2
`define FCTL_TYPE_LSB 4
`define FCTL_TYPE_MSB 7
`define FCOEF_VAL_MSB 17
`define FCOEF_IDX_LSB 20
`define FCOEF_IDX_MSB 22
`define FCOEF_SECT_LSB 24
`define FCOEF_SECT_MSB 25
`define LIM_MAX_LSB 8

// ****************************************
// Reset values and ranges (dB, dBu, codes)
// ****************************************
`define CTRL_DEF 8'h00
`define THR_MIN 8'hE2
`define THR_MAX 8'h14
`define THR_DEF 8'h00
`define RATIO_MIN 5'h01
`define RATIO_MAX 5'h14
`define RATIO_DEF 5'h01
`define ATK_MAX 8'hC8
`define ATK_DEF 8'h14
`define REL_MIN 9'h014
`define REL_MAX 9'h190
`define REL_DEF 9'h064
`define GAIN_MIN 8'hBF
`define GAIN_MAX 8'h14
`define GAIN_DEF 8'h00
`define GAIN_MUTE_BELOW 8'hC4
`define LEVEL_FS_DBU 8'h14

// ****************************************
// Timing
// ****************************************
`define ATK_STEP_US 500
`define REL_STEP_US 5000
`define ATK_SMP_PER_CODE (`ATK_STEP_US * `FS_HZ / 1000000)
`define REL_SMP_PER_CODE (`REL_STEP_US * `FS_HZ / 1000000)
`define GR_STEP_SHIFT 6
`define RMS_SHIFT 6
`define DLY_MAX_MS 500
`define DLY_DEPTH (`DLY_MAX_MS * `FS_HZ / 1000)
`define DLY_AW 15

`endif

//--- core/proc_chan_pkg.sv
// Purpose: Types shared by the processing channel
// Assumes: Constants come from proc_chan_map.svh
// Notes: Filter type codes follow declaration order
package proc_chan_pkg;
   typedef enum logic [3:0] {
      FT_NONE, FT_ALLPASS, FT_BESSEL, FT_BUTTER, FT_CDHORN, FT_HIPASS,
      FT_HISHELF, FT_LINKRILEY, FT_LOPASS, FT_LOSHELF, FT_NOTCH, FT_PEQ
   } filt_type_e;
   typedef logic signed [23:0] sample_t;
   typedef logic signed [17:0] coef_t;
endpackage

//--- core/proc_channel.sv
// Purpose: Eight time-shared audio processing channels
// Assumes: One sample beat per cycle at most, channel tagged on in_chan
// Notes: Two cycle latency from in_valid to out_valid
//
// Summary of operation
// - Eight independent, individually addressable channels
// - Mute silences output, cleared at reset
// - Above threshold reduce gain by ratio, attack/release
// - Compressor acts only while enabled
// - Grouped compressors share gain reduction; default none
// - RMS threshold -30..+20 dBu, default 0
// - Ratio 1:1 to 1:20, default 1:1
// - Attack 0..100 ms, 0.5 ms steps, default 10
// - Release 100 ms..2 s, 5 ms steps, default 500
// - Peak input meter at compressor input
// - Peak-held gain reduction meter readable
// - Filter sections of all listed types
// - Per-section enable keeps coefficients; the same write sets the type
// - Global bypass skips every filter section
// - Reset: sections disabled, no type, transparent
// - Delay up to 500 ms
// - Delay bypass skips programmed delay
// - Gain -65..20 dB, below -60 mutes
// - Limits clamp relative gain, absolute unclamped
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "proc_chan_map.svh"

module proc_channel import proc_chan_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input wire logic in_valid,
   input wire logic [2:0] in_chan,
   input wire logic signed [23:0] in_data,
   output logic out_valid,
   output logic [2:0] out_chan,
   output logic signed [23:0] out_data,
   input wire logic [6:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic sample_t sat24(input logic signed [47:0] v);
      if (v > 48'sh0000_007F_FFFF) sat24 = 24'h7F_FFFF;
      else if (v < -48'sh0000_0080_0000) sat24 = 24'h80_0000;
      else sat24 = v[23:0];
   endfunction

   function automatic logic signed [7:0] clamp8(input logic signed [9:0] v,
                                                input logic signed [7:0] lo,
                                                input logic signed [7:0] hi);
      if (v < 10'(lo)) clamp8 = lo;
      else if (v > 10'(hi)) clamp8 = hi;
      else clamp8 = v[7:0];
   endfunction

   // Quarter-dB code to linear gain, piecewise linear per 6 dB octave
   function automatic logic [19:0] db_to_lin(input logic signed [10:0] q);
      logic [10:0] v;
      logic [5:0] sh;
      logic [4:0] fr;
      logic [47:0] m;
      v = 11'(q + 11'sd576);
      sh = 6'(v / 11'd24);
      fr = 5'(v % 11'd24);
      m = 48'(16'h4000 + 16'(fr) * 16'h02AB) << sh;
      db_to_lin = 20'(m >> 24);
   endfunction

   function automatic logic [4:0] lead_pos(input logic [23:0] v);
      lead_pos = 5'h00;
      for (int i = 0; i < 24; i++) if (v[i]) lead_pos = 5'(i);
   endfunction

   // ****************************************
   // Configuration registers
   // ****************************************
   logic [7:0] ctrl_ff [`NUM_CHAN];
   logic signed [7:0] thr_ff [`NUM_CHAN];
   logic [4:0] ratio_ff [`NUM_CHAN];
   logic [7:0] atk_ff [`NUM_CHAN];
   logic [8:0] rel_ff [`NUM_CHAN];
   logic signed [7:0] gain_ff [`NUM_CHAN];
   logic signed [7:0] gmin_ff [`NUM_CHAN];
   logic signed [7:0] gmax_ff [`NUM_CHAN];
   logic [14:0] dly_ff [`NUM_CHAN];
   logic sect_en_ff [`NUM_CHAN][`NUM_SECT];
   filt_type_e ftype_ff [`NUM_CHAN][`NUM_SECT];
   coef_t coef_ff [`NUM_CHAN][`NUM_SECT][`NUM_COEF];
   logic [2:0] wchan;
   logic [3:0] wreg;
   logic [1:0] fsel;
   logic [2:0] cidx;
   logic signed [9:0] gain_rel;

   assign wchan = addr[6:4];
   assign wreg = addr[3:0];
   assign fsel = wdata[`FCOEF_SECT_MSB:`FCOEF_SECT_LSB];
   assign cidx = wdata[`FCOEF_IDX_MSB:`FCOEF_IDX_LSB];
   assign gain_rel = 10'(gain_ff[wchan]) + 10'(signed'(wdata[7:0]));

   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int c = 0; c < `NUM_CHAN; c++) begin
            ctrl_ff[c] <= `CTRL_DEF;
            thr_ff[c] <= `THR_DEF;
            ratio_ff[c] <= `RATIO_DEF;
            atk_ff[c] <= `ATK_DEF;
            rel_ff[c] <= `REL_DEF;
            gain_ff[c] <= `GAIN_DEF;
            gmin_ff[c] <= `GAIN_MIN;
            gmax_ff[c] <= `GAIN_MAX;
            dly_ff[c] <= 15'h0000;
         end
      end else if (wr) begin
         case (wreg)
            `REG_CTRL: ctrl_ff[wchan] <= wdata[7:0];
            `REG_THRESH: thr_ff[wchan] <= clamp8(10'(signed'(wdata[7:0])),
                                                 `THR_MIN, `THR_MAX);
            `REG_RATIO: begin
               if (wdata[4:0] < `RATIO_MIN) ratio_ff[wchan] <= `RATIO_MIN;
               else if (wdata[4:0] > `RATIO_MAX) ratio_ff[wchan] <= `RATIO_MAX;
               else ratio_ff[wchan] <= wdata[4:0];
            end
            `REG_ATTACK: atk_ff[wchan] <= (wdata[7:0] > `ATK_MAX) ? `ATK_MAX :
                                          wdata[7:0];
            `REG_RELEASE: begin
               if (wdata[8:0] < `REL_MIN) rel_ff[wchan] <= `REL_MIN;
               else if (wdata[8:0] > `REL_MAX) rel_ff[wchan] <= `REL_MAX;
               else rel_ff[wchan] <= wdata[8:0];
            end
            `REG_GAIN_ABS: gain_ff[wchan] <= clamp8(10'(signed'(wdata[7:0])),
                                                    `GAIN_MIN, `GAIN_MAX);
            `REG_GAIN_REL: gain_ff[wchan] <= clamp8(gain_rel, gmin_ff[wchan],
                                                    gmax_ff[wchan]);
            `REG_GAIN_LIM: begin
               gmin_ff[wchan] <= clamp8(10'(signed'(wdata[7:0])), `GAIN_MIN, `GAIN_MAX);
               gmax_ff[wchan] <= clamp8(10'(signed'(wdata[15:8])), `GAIN_MIN, `GAIN_MAX);
            end
            `REG_DELAY: dly_ff[wchan] <= (wdata[14:0] > 15'(`DLY_DEPTH - 1)) ?
                                         15'(`DLY_DEPTH - 1) : wdata[14:0];
            default: ;
         endcase
      end
   end

   // Filter section settings; disabling keeps coefficients, the same write also sets the type
   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int c = 0; c < `NUM_CHAN; c++) begin
            for (int s = 0; s < `NUM_SECT; s++) begin
               sect_en_ff[c][s] <= 1'b0;
               ftype_ff[c][s] <= FT_NONE;
               for (int k = 0; k < `NUM_COEF; k++) coef_ff[c][s][k] <= 18'h0_0000;
            end
         end
      end else if (wr && wreg == `REG_FILT_CTRL) begin
         sect_en_ff[wchan][wdata[`FCTL_SECT_MSB:`FCTL_SECT_LSB]] <= wdata[`FCTL_EN];
         ftype_ff[wchan][wdata[`FCTL_SECT_MSB:`FCTL_SECT_LSB]] <=
            filt_type_e'(wdata[`FCTL_TYPE_MSB:`FCTL_TYPE_LSB]);
      end else if (wr && wreg == `REG_FILT_COEF && cidx < 3'(`NUM_COEF)) begin
         coef_ff[wchan][fsel][cidx] <= wdata[`FCOEF_VAL_MSB:0];
      end
   end

   // ****************************************
   // Compressor
   // ****************************************
   logic [2:0] c;
   logic signed [24:0] ms_ff [`NUM_CHAN];
   logic [7:0] gr_ff [`NUM_CHAN];
   logic [15:0] gcnt_ff [`NUM_CHAN];
   logic [22:0] in_abs;
   logic [47:0] sq;
   logic signed [24:0] nxt_ms;
   logic signed [7:0] lvl_db;
   logic signed [8:0] over;
   logic [7:0] gr_tgt;
   logic [15:0] gr_ivl;
   logic [7:0] gr_eff;
   logic [2:0] grp_c;

   assign c = in_chan;
   assign grp_c = ctrl_ff[c][`CTRL_GRP_MSB:`CTRL_GRP_LSB];
   assign in_abs = in_data[23] ? 23'(-in_data) : in_data[22:0];
   assign sq = 48'(in_abs) * 48'(in_abs);

   always_comb begin
      logic [15:0] tq;
      tq = 16'h0000;
      nxt_ms = ms_ff[c] + ((signed'(25'(sq[45:22])) - ms_ff[c]) >>> `RMS_SHIFT);
      lvl_db = `LEVEL_FS_DBU - 8'(8'd3 * (8'd23 - 8'(lead_pos(24'(ms_ff[c])))));
      over = 9'(lvl_db) - 9'(thr_ff[c]);
      tq = 16'(over[7:0]) * 16'd4 * 16'(ratio_ff[c] - 5'h01) / 16'(ratio_ff[c]);
      if (!ctrl_ff[c][`CTRL_CMP_EN] || over <= 9'sd0) gr_tgt = 8'h00;
      else gr_tgt = (tq > 16'h00FF) ? 8'hFF : tq[7:0];
      if (gr_tgt > gr_ff[c])
         gr_ivl = 16'((32'(atk_ff[c]) * `ATK_SMP_PER_CODE) >> `GR_STEP_SHIFT);
      else
         gr_ivl = 16'((32'(rel_ff[c]) * `REL_SMP_PER_CODE) >> `GR_STEP_SHIFT);
      gr_eff = gr_ff[c];
      for (int j = 0; j < `NUM_CHAN; j++)
         if (grp_c != 3'h0 && ctrl_ff[j][`CTRL_GRP_MSB:`CTRL_GRP_LSB] == grp_c &&
             gr_ff[j] > gr_eff)
            gr_eff = gr_ff[j];
      if (!ctrl_ff[c][`CTRL_CMP_EN]) gr_eff = 8'h00;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int j = 0; j < `NUM_CHAN; j++) begin
            ms_ff[j] <= 25'h000_0000;
            gr_ff[j] <= 8'h00;
            gcnt_ff[j] <= 16'h0000;
         end
      end else if (in_valid) begin
         ms_ff[c] <= nxt_ms;
         if (gr_tgt == gr_ff[c]) begin
            gcnt_ff[c] <= 16'h0000;
         end else if (gcnt_ff[c] >= gr_ivl) begin
            gcnt_ff[c] <= 16'h0000;
            gr_ff[c] <= (gr_tgt > gr_ff[c]) ? gr_ff[c] + 8'h01 : gr_ff[c] - 8'h01;
         end else begin
            gcnt_ff[c] <= gcnt_ff[c] + 16'h0001;
         end
      end
   end

   // ****************************************
   // Meters, cleared by their read
   // ****************************************
   logic [22:0] in_pk_ff [`NUM_CHAN];
   logic [7:0] gr_pk_ff [`NUM_CHAN];

   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int j = 0; j < `NUM_CHAN; j++) begin
            in_pk_ff[j] <= 23'h00_0000;
            gr_pk_ff[j] <= 8'h00;
         end
      end else begin
         for (int j = 0; j < `NUM_CHAN; j++) begin
            logic [22:0] ib;
            logic [7:0] gb;
            ib = (rd && wchan == 3'(j) && wreg == `REG_IN_METER) ? 23'h00_0000 : in_pk_ff[j];
            gb = (rd && wchan == 3'(j) && wreg == `REG_GR_METER) ? 8'h00 : gr_pk_ff[j];
            if (in_valid && c == 3'(j) && in_abs > ib) ib = in_abs;
            if (in_valid && c == 3'(j) && gr_eff > gb) gb = gr_eff;
            in_pk_ff[j] <= ib;
            gr_pk_ff[j] <= gb;
         end
      end
   end

   // ****************************************
   // Compressor gain, then filter bank
   // ****************************************
   sample_t x_cmp;
   sample_t sect_in [`NUM_SECT];
   sample_t sect_out [`NUM_SECT];
   logic sect_act [`NUM_SECT];
   sample_t fx1_ff [`NUM_CHAN][`NUM_SECT];
   sample_t fx2_ff [`NUM_CHAN][`NUM_SECT];
   sample_t fy1_ff [`NUM_CHAN][`NUM_SECT];
   sample_t fy2_ff [`NUM_CHAN][`NUM_SECT];
   sample_t filt_out;

   always_comb begin
      sample_t v;
      logic signed [47:0] acc;
      acc = 48'sh0000_0000_0000;
      x_cmp = sat24((48'(in_data) * 48'(signed'({1'b0, db_to_lin(-11'(gr_eff))})))
                    >>> `GAIN_FRAC);
      v = x_cmp;
      for (int s = 0; s < `NUM_SECT; s++) begin
         sect_in[s] = v;
         sect_act[s] = sect_en_ff[c][s] && ftype_ff[c][s] != FT_NONE &&
                       !ctrl_ff[c][`CTRL_FILT_BYP];
         acc = 48'(coef_ff[c][s][0]) * 48'(v) + 48'(coef_ff[c][s][1]) * 48'(fx1_ff[c][s])
             + 48'(coef_ff[c][s][2]) * 48'(fx2_ff[c][s])
             - 48'(coef_ff[c][s][3]) * 48'(fy1_ff[c][s])
             - 48'(coef_ff[c][s][4]) * 48'(fy2_ff[c][s]);
         sect_out[s] = sat24(acc >>> `COEF_FRAC);
         if (sect_act[s]) v = sect_out[s];
      end
      filt_out = v;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int j = 0; j < `NUM_CHAN; j++) begin
            for (int s = 0; s < `NUM_SECT; s++) begin
               fx1_ff[j][s] <= 24'h00_0000;
               fx2_ff[j][s] <= 24'h00_0000;
               fy1_ff[j][s] <= 24'h00_0000;
               fy2_ff[j][s] <= 24'h00_0000;
            end
         end
      end else if (in_valid) begin
         for (int s = 0; s < `NUM_SECT; s++) begin
            if (sect_act[s]) begin
               fx1_ff[c][s] <= sect_in[s];
               fx2_ff[c][s] <= fx1_ff[c][s];
               fy1_ff[c][s] <= sect_out[s];
               fy2_ff[c][s] <= fy1_ff[c][s];
            end
         end
      end
   end

   // ****************************************
   // Delay line
   // ****************************************
   sample_t dmem [`NUM_CHAN][`DLY_DEPTH];
   logic [`DLY_AW-1:0] wptr_ff [`NUM_CHAN];
   logic [`DLY_AW-1:0] raddr;
   sample_t drd_ff;
   sample_t s1_dir_ff;
   logic s1_valid_ff;
   logic s1_use_dly_ff;
   logic [2:0] s1_chan_ff;

   assign raddr = (wptr_ff[c] >= dly_ff[c]) ? wptr_ff[c] - dly_ff[c] :
                  `DLY_AW'(wptr_ff[c] + `DLY_AW'(`DLY_DEPTH) - dly_ff[c]);

   always_ff @(posedge clk) begin
      if (in_valid) begin
         dmem[c][wptr_ff[c]] <= filt_out;
         drd_ff <= dmem[c][raddr];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int j = 0; j < `NUM_CHAN; j++) wptr_ff[j] <= `DLY_AW'(0);
      end else if (in_valid) begin
         wptr_ff[c] <= (wptr_ff[c] == `DLY_AW'(`DLY_DEPTH - 1)) ? `DLY_AW'(0) :
                       wptr_ff[c] + `DLY_AW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s1_valid_ff <= 1'b0;
         s1_chan_ff <= 3'h0;
         s1_dir_ff <= 24'h00_0000;
         s1_use_dly_ff <= 1'b0;
      end else begin
         s1_valid_ff <= in_valid;
         s1_chan_ff <= c;
         s1_dir_ff <= filt_out;
         s1_use_dly_ff <= !ctrl_ff[c][`CTRL_DLY_BYP] && dly_ff[c] != 15'h0000;
      end
   end

   // ****************************************
   // Gain and mute
   // ****************************************
   sample_t s1_smp;
   logic s1_mute;
   logic [19:0] glin;

   assign s1_smp = s1_use_dly_ff ? drd_ff : s1_dir_ff;
   assign s1_mute = ctrl_ff[s1_chan_ff][`CTRL_MUTE] ||
                    gain_ff[s1_chan_ff] < signed'(`GAIN_MUTE_BELOW);
   assign glin = db_to_lin(11'(gain_ff[s1_chan_ff]) * 11'sd4);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         out_valid <= 1'b0;
         out_chan <= 3'h0;
         out_data <= 24'h00_0000;
      end else begin
         out_valid <= s1_valid_ff;
         out_chan <= s1_chan_ff;
         if (s1_mute) out_data <= 24'h00_0000;
         else out_data <= sat24((48'(s1_smp) * 48'(signed'({1'b0, glin}))) >>> `GAIN_FRAC);
      end
   end

   // ****************************************
   // Register read
   // ****************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         case (wreg)
            `REG_CTRL: rdata <= 32'(ctrl_ff[wchan]);
            `REG_THRESH: rdata <= 32'(unsigned'(thr_ff[wchan]));
            `REG_RATIO: rdata <= 32'(ratio_ff[wchan]);
            `REG_ATTACK: rdata <= 32'(atk_ff[wchan]);
            `REG_RELEASE: rdata <= 32'(rel_ff[wchan]);
            `REG_GAIN_ABS: rdata <= 32'(unsigned'(gain_ff[wchan]));
            `REG_GAIN_LIM: rdata <= {16'h0000, gmax_ff[wchan], gmin_ff[wchan]};
            `REG_DELAY: rdata <= 32'(dly_ff[wchan]);
            `REG_IN_METER: rdata <= 32'(in_pk_ff[wchan]);
            `REG_GR_METER: rdata <= 32'(gr_pk_ff[wchan]);
            `REG_FILT_CTRL: begin
               rdata <= 32'h0000_0000;
               for (int s = 0; s < `NUM_SECT; s++)
                  rdata[s*8 +: 8] <= {ftype_ff[wchan][s], 3'h0, sect_en_ff[wchan][s]};
            end
            default: rdata <= 32'h0000_0000;
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

endmodule // proc_channel

//--- test/proc_channel_chk_sva.sv
// Purpose: Port-level checks of the processing channel
// Assumes: Register index in addr[3:0], channel in addr[6:4]
// Notes: Mute is shadowed from control writes
`timescale 1ns/100ps
`include "proc_chan_map.svh"
module proc_channel_chk import proc_chan_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input wire logic in_valid,
   input wire logic [2:0] in_chan,
   input wire logic signed [23:0] in_data,
   input wire logic out_valid,
   input wire logic [2:0] out_chan,
   input wire logic signed [23:0] out_data,
   input wire logic [6:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata
);
   logic [7:0] mute_ff;
   logic rd_g, rd_t, rd_r, rd_a, rd_l, rd_d;
   assign rd_g = rd && addr[3:0] == `REG_GAIN_ABS;
   assign rd_t = rd && addr[3:0] == `REG_THRESH;
   assign rd_r = rd && addr[3:0] == `REG_RATIO;
   assign rd_a = rd && addr[3:0] == `REG_ATTACK;
   assign rd_l = rd && addr[3:0] == `REG_RELEASE;
   assign rd_d = rd && addr[3:0] == `REG_DELAY;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mute_ff <= 8'h00;
      end else if (wr && addr[3:0] == `REG_CTRL) begin
         mute_ff[addr[6:4]] <= wdata[`CTRL_MUTE];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ****
   // Stream and register checks
   // ****
   a_beat_lat: assert property (in_valid |-> ##2 out_valid)
      else $error("output beat missing");
   a_beat_chan: assert property (in_valid |-> ##2 out_chan == $past(in_chan, 2))
      else $error("output channel wrong");
   a_no_extra: assert property (out_valid |-> $past(in_valid, 2))
      else $error("output beat without input");
   a_mute_silent: assert property (out_valid && mute_ff[out_chan] && !$past(wr)
      && !$past(wr, 2) |-> out_data == 24'h00_0000) else $error("muted output not zero");
   a_gain_range: assert property (rd_g |=> $signed(rdata[7:0]) >= -65
      && $signed(rdata[7:0]) <= 20) else $error("gain out of range");
   a_thr_range: assert property (rd_t |=> $signed(rdata[7:0]) >= -30
      && $signed(rdata[7:0]) <= 20) else $error("threshold out of range");
   a_ratio_range: assert property (rd_r |=> rdata inside {[1:20]})
      else $error("ratio out of range");
   a_atk_range: assert property (rd_a |=> rdata <= 32'h0000_00C8)
      else $error("attack out of range");
   a_rel_range: assert property (rd_l |=> rdata inside {[20:400]})
      else $error("release out of range");
   a_dly_max: assert property (rd_d |=> rdata <= 32'h0000_5DBF)
      else $error("delay above maximum");
   c_muted: cover property (out_valid && mute_ff[out_chan]);
   c_gr_read: cover property (rd && addr[3:0] == `REG_GR_METER);
   c_coef_wr: cover property (wr && addr[3:0] == `REG_FILT_COEF);
endmodule // proc_channel_chk
bind proc_channel proc_channel_chk i_chk (.clk, .nrst, .in_valid, .in_chan, .in_data,
   .out_valid, .out_chan, .out_data, .addr, .wdata, .wr, .rd, .rdata);

//--- test/chan_stream_model.sv
// Purpose: Routing matrix side: sample source and sink
// Assumes: No back-pressure on either direction
// Notes: Idle data line shows the inverse of the last sample
`timescale 1ns/100ps
module chan_stream_model import proc_chan_pkg::*; (
   input wire logic clk,
   output logic in_valid,
   output logic [2:0] in_chan,
   output sample_t in_data,
   input wire logic out_valid,
   input wire sample_t out_data
);
   sample_t got[$];
   initial begin
      in_valid = 1'b0;
      in_chan = 3'h0;
      in_data = 24'h00_0000;
   end
   always @(posedge clk) begin
      if (out_valid) got.push_back(out_data);
   end
   // Back-to-back beats d, d+1, ...
   task automatic send(input logic [2:0] c, input sample_t d, input int n);
      got.delete();
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         in_valid <= 1'b1;
         in_chan <= c;
         in_data <= d + 24'(i);
      end
      @(posedge clk);
      in_valid <= 1'b0;
      in_data <= ~in_data;
      repeat (4) @(posedge clk);
   endtask
endmodule // chan_stream_model

//--- test/audio_processing_channel_test.sv
// Purpose: Register and stream tests of the processing channel
// Assumes: 0 dB gain passes samples unchanged
// Notes: Checker is bound to the design
`timescale 1ns/100ps
`include "proc_chan_map.svh"
module audio_processing_channel_test import proc_chan_pkg::*; ;
   logic clk, nrst, wr, rd, in_valid, out_valid;
   logic [6:0] addr;
   logic [31:0] wdata, rdata, v;
   logic [2:0] in_chan, out_chan;
   sample_t in_data, out_data;
   int n_mismatch = 0, total_checks = 0;
   localparam logic [3:0] rst_reg [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8,
      4'h9, 4'hA, 4'hB, 4'hD};
   localparam logic [15:0] rst_exp [12] = '{16'h0000, 16'h0000, 16'h0001, 16'h0014,
      16'h0064, 16'h0000, 16'h14BF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [3:0] clp_reg [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8};
   localparam logic [15:0] clp_wr [6] = '{16'h00CE, 16'h001E, 16'h00FF, 16'h0005,
      16'h0080, 16'h7530};
   localparam logic [15:0] clp_exp [6] = '{16'h00E2, 16'h0014, 16'h00C8, 16'h0014,
      16'h00BF, 16'h5DBF};
   proc_channel i_dut (.clk(clk), .nrst(nrst), .in_valid(in_valid), .in_chan(in_chan),
      .in_data(in_data), .out_valid(out_valid), .out_chan(out_chan), .out_data(out_data),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   chan_stream_model i_src (.clk(clk), .in_valid(in_valid), .in_chan(in_chan),
      .in_data(in_data), .out_valid(out_valid), .out_data(out_data));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ****
   // Bus and compare tasks
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [2:0] c, input logic [3:0] r, input logic [31:0] d);
      @(posedge clk);
      addr <= {c, r};
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] c, input logic [3:0] r);
      @(posedge clk);
      addr <= {c, r};
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic rd_chk(input logic [2:0] c, input logic [3:0] r, input logic [31:0] e);
      rd_reg(c, r);
      chk(v, e);
   endtask
   task automatic beat(input logic [2:0] c, input sample_t d, input sample_t e);
      i_src.send(c, d, 1);
      chk({8'h00, i_src.got[0]}, {8'h00, e});
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
   // ****
   // Tests
   // ****
   initial begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 7'h00;
      wdata = 32'h0000_0000;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         rd_chk(3'd7, rst_reg[i], {16'h0000, rst_exp[i]});
      end
      for (int i = 0; i < 6; i++) begin
         wr_reg(3'd6, clp_reg[i], {16'h0000, clp_wr[i]});
         rd_chk(3'd6, clp_reg[i], {16'h0000, clp_exp[i]});
      end
      $display("test reset_and_range done");
      wr_reg(3'd3, `REG_CTRL, 32'h0000_0001);
      beat(3'd3, 24'h12_3456, 24'h00_0000);
      beat(3'd0, 24'h12_3456, 24'h12_3456);
      wr_reg(3'd3, `REG_CTRL, 32'h0000_0000);
      beat(3'd3, 24'h12_3456, 24'h12_3456);
      wr_reg(3'd2, `REG_GAIN_ABS, 32'h0000_00C3);
      beat(3'd2, 24'h10_0000, 24'h00_0000);
      wr_reg(3'd2, `REG_GAIN_LIM, 32'h0000_05F6);
      wr_reg(3'd2, `REG_GAIN_ABS, 32'h0000_0000);
      wr_reg(3'd2, `REG_GAIN_REL, 32'h0000_0014);
      rd_chk(3'd2, `REG_GAIN_ABS, 32'h0000_0005);
      wr_reg(3'd2, `REG_GAIN_REL, 32'h0000_00D8);
      rd_chk(3'd2, `REG_GAIN_ABS, 32'h0000_00F6);
      wr_reg(3'd2, `REG_GAIN_ABS, 32'h0000_0014);
      rd_chk(3'd2, `REG_GAIN_ABS, 32'h0000_0014);
      $display("test mute_and_gain done");
      wr_reg(3'd0, `REG_DELAY, 32'h0000_000A);
      i_src.send(3'd0, 24'h00_1000, 20);
      for (int k = 10; k < 20; k++) begin
         chk({8'h00, i_src.got[k]}, {8'h00, 24'h00_1000 + 24'(k - 10)});
      end
      wr_reg(3'd0, `REG_CTRL, 32'h0000_0008);
      beat(3'd0, 24'h00_2000, 24'h00_2000);
      beat(3'd7, 24'hE0_0000, 24'hE0_0000);
      beat(3'd7, 24'h10_0000, 24'h10_0000);
      rd_chk(3'd7, `REG_IN_METER, 32'h0020_0000);
      rd_chk(3'd7, `REG_IN_METER, 32'h0000_0000);
      $display("test delay_and_meter done");
      for (int k = 0; k < 5; k++) begin
         wr_reg(3'd1, `REG_FILT_COEF, (k == 0) ? 32'h0000_8000 : {9'h000, 3'(k), 20'h0_0000});
      end
      wr_reg(3'd1, `REG_FILT_CTRL, 32'h0000_00B4);
      beat(3'd1, 24'h01_0000, 24'h00_8000);
      rd_chk(3'd1, `REG_FILT_CTRL, 32'h0000_00B1);
      wr_reg(3'd1, `REG_CTRL, 32'h0000_0004);
      beat(3'd1, 24'h01_0000, 24'h01_0000);
      wr_reg(3'd1, `REG_CTRL, 32'h0000_0000);
      wr_reg(3'd1, `REG_FILT_CTRL, 32'h0000_00B0);
      beat(3'd1, 24'h01_0000, 24'h01_0000);
      wr_reg(3'd1, `REG_FILT_CTRL, 32'h0000_00B4);
      beat(3'd1, 24'h01_0000, 24'h00_8000);
      for (int t = 1; t < 12; t++) begin
         wr_reg(3'd1, `REG_FILT_CTRL, {24'h00_0000, 4'(t), 4'h5});
         rd_chk(3'd1, `REG_FILT_CTRL, {16'h0000, 4'(t), 4'h1, 8'hB1});
      end
      wr_reg(3'd1, `REG_FILT_CTRL, 32'h0000_0001);
      $display("test filters done");
      wr_reg(3'd4, `REG_THRESH, 32'h0000_00E2);
      wr_reg(3'd4, `REG_RATIO, 32'h0000_0014);
      wr_reg(3'd4, `REG_ATTACK, 32'h0000_0000);
      wr_reg(3'd4, `REG_CTRL, 32'h0000_0012);
      wr_reg(3'd5, `REG_CTRL, 32'h0000_0012);
      i_src.send(3'd4, 24'h60_0000, 400);
      chk({31'h0000_0000, i_src.got[399] < 24'h60_0000}, 32'h0000_0001);
      rd_reg(3'd4, `REG_GR_METER);
      chk({31'h0000_0000, v != 32'h0000_0000}, 32'h0000_0001);
      i_src.send(3'd5, 24'h00_0100, 4);
      rd_reg(3'd5, `REG_GR_METER);
      chk({31'h0000_0000, v != 32'h0000_0000}, 32'h0000_0001);
      i_src.send(3'd6, 24'h60_0000, 400);
      rd_chk(3'd6, `REG_GR_METER, 32'h0000_0000);
      $display("test compressor done");
      close_out();
   end
endmodule // audio_processing_channel_test
